// File: sim/pdmc_far_model.sv
// Far-side model: interrupt logic, bus cycle timing and reset pin driver
`timescale 1ns/1ps
module pdmc_far_model #(
  parameter int HOLD = 12
)(
  // Clock
  input  wire logic clk_in,
  // Bench requests
  input  wire logic irq_req_in,
  input  wire logic cpu_mask_in,
  input  wire logic rst_req_in,
  // To the block
  output logic      irq_accept_out,
  output logic      bus_cycle_end_out,
  output logic      reset_pin_n_out
);
  logic [2:0] phase_q = 3'h0;
  logic [7:0] hold_q  = 8'h00;
  //////////////////////////////////////////////////////////////////////////////
  // Masked requests are never accepted
  assign irq_accept_out    = irq_req_in & ~cpu_mask_in;
  // One bus cycle every eight clocks
  assign bus_cycle_end_out = (phase_q == 3'h7);
  // Reset pin held low while requested and for HOLD clocks after the request ends
  assign reset_pin_n_out   = (hold_q == 8'h00);
  always_ff @(posedge clk_in)
  begin
    phase_q <= phase_q + 3'h1;
    if (rst_req_in)
      hold_q <= 8'(HOLD);
    else if (hold_q != 8'h00)
      hold_q <= hold_q - 8'h01;
  end
endmodule : pdmc_far_model

// File: sim/pdmc_top_tb.sv
// Self-checking bench of the power-down mode controller
`timescale 1ns/1ps
module pdmc_top_tb;
  import pdmc_pkg::*;
  localparam int unsigned BASE = 16;
  logic        clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, sleep = 1'b0;
  logic        mask = 1'b0, hpin = 1'b1, nmi = 1'b0, xreq = 1'b0;
  logic        irq_req = 1'b0, rst_req = 1'b0;
  logic [4:0]  addr = '0;
  logic [31:0] wdata = '0;
  logic [7:0]  irq_en = '0;
  logic [7:0]  irqn = 8'hFF;
  logic [31:0] rdata;
  logic        wreq, irq_acc, halt, iexc, rexc, rstate, rpin, osc, cen, hws, bend;
  logic [15:0] mstop, lost, blk;
  int          error_cnt = 0;
  int          total_checks = 0;
  //////////////////////////////////////////////////////////////////////////////
  initial forever #12.5 clk = ~clk;
  pdmc_top #(.SETTLE_BASE(BASE)) dut (
    .ref_clk_in(clk), .resetn_in(rstn), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .sleep_instr_in(sleep), .irq_accept_in(irq_acc),
    .cpu_mask_in(mask), .irq_enable_in(irq_en), .cpu_halt_out(halt),
    .irq_exc_start_out(iexc), .reset_exc_start_out(rexc), .reset_state_out(rstate),
    .reset_pin_n_in(rpin), .hw_standby_pin_n_in(hpin), .nmi_pin_in(nmi),
    .irq_pin_n_in(irqn), .osc_enable_out(osc), .chip_clk_enable_out(cen),
    .hw_standby_out(hws), .xfer_bus_req_in(xreq), .bus_cycle_end_in(bend),
    .module_stop_out(mstop), .module_state_lost_out(lost), .reg_access_block_out(blk));
  pdmc_far_model #(.HOLD(12)) far (
    .clk_in(clk), .irq_req_in(irq_req), .cpu_mask_in(mask), .rst_req_in(rst_req),
    .irq_accept_out(irq_acc), .bus_cycle_end_out(bend), .reset_pin_n_out(rpin));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    @(posedge clk);
    rd <= ~we;
    wr <= we;
    addr <= a;
    wdata <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) chk("bus_answer", 32'h0, 32'h1);
  endtask : bus
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr_reg
  task automatic rd_chk(input string what, input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(what, 32'(exp), 32'(q));
  endtask : rd_chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic pulse_sleep;
    @(posedge clk);
    sleep <= 1'b1;
    @(posedge clk);
    sleep <= 1'b0;
  endtask : pulse_sleep
  // Waits for an exception pulse, counting gated-clock settle cycles
  task automatic wait_exc(input logic want_rst, output int settle);
    int n;
    settle = 0;
    n = 0;
    @(posedge clk);
    while ((want_rst ? rexc : iexc) !== 1'b1 && n < 5000)
    begin
      if (osc === 1'b1 && cen === 1'b0) settle++;
      @(posedge clk);
      n++;
    end
    if (n >= 5000) chk("exc_wait", 32'h0, 32'h1);
  endtask : wait_exc
  task automatic enter_hw_standby_pin_n(input logic [7:0] cfg);
    wr_reg(HW_STANDBY_PIN_N_CTRL_OFS, cfg);
    pulse_sleep;
    tick(3);
    chk("osc_enable", 32'h0, 32'(osc));
    chk("clk_enable", 32'h0, 32'(cen));
  endtask : enter_hw_standby_pin_n
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    tick(4);
    chk("stop_out", 32'h3FFC, 32'(mstop));
    rd_chk("stop_high", STOP_HIGH_OFS, 8'h3F);
    rd_chk("stop_low", STOP_LOW_OFS, 8'hFF);
    rd_chk("unmapped", 5'h1C, 8'h00);
    rd_chk("status", STATUS_OFS, 8'h00);
  endtask : t_reset
  task automatic t_stop;
    wr_reg(STOP_HIGH_OFS, 8'h2A);
    wr_reg(STOP_LOW_OFS, 8'hE3);
    tick(12);
    chk("stop_out", 32'h2AE0, 32'(mstop));
    chk("access_block", 32'h2AE0, 32'(blk));
    chk("state_lost", 32'h0AE0, 32'(lost));
    rd_chk("stop_low", STOP_LOW_OFS, 8'hE3);
    wr_reg(STOP_HIGH_OFS, 8'h00);
    wr_reg(STOP_LOW_OFS, 8'h03);
    tick(12);
    chk("stop_out", 32'h0000, 32'(mstop));
    chk("state_lost", 32'h0000, 32'(lost));
  endtask : t_stop
  task automatic t_collide;
    @(posedge clk);
    xreq <= 1'b1;
    wr_reg(STOP_HIGH_OFS, 8'h40);
    rd_chk("stop_high", STOP_HIGH_OFS, 8'h00);
    @(posedge clk);
    xreq <= 1'b0;
    wr_reg(STOP_HIGH_OFS, 8'h40);
    tick(12);
    chk("stop_out", 32'h4000, 32'(mstop));
  endtask : t_collide
  task automatic t_mode_bits;
    wr_reg(TMR_CTRL_OFS, 8'h10);
    rd_chk("prescale", TMR_CTRL_OFS, 8'h10);
    wr_reg(HW_STANDBY_PIN_N_CTRL_OFS, 8'h80);
    pulse_sleep;
    tick(3);
    chk("cpu_halt", 32'h0, 32'(halt));
    wr_reg(TMR_CTRL_OFS, 8'h00);
    wr_reg(LOW_PWR_OFS, 8'h40);
    rd_chk("low_speed", LOW_PWR_OFS, 8'h40);
    wr_reg(HW_STANDBY_PIN_N_CTRL_OFS, 8'h00);
    pulse_sleep;
    tick(3);
    chk("cpu_halt", 32'h0, 32'(halt));
    wr_reg(LOW_PWR_OFS, 8'h00);
  endtask : t_mode_bits
  task automatic t_sleep;
    int n;
    wr_reg(HW_STANDBY_PIN_N_CTRL_OFS, 8'h00);
    pulse_sleep;
    tick(2);
    chk("cpu_halt", 32'h1, 32'(halt));
    chk("clk_enable", 32'h1, 32'(cen));
    rd_chk("status", STATUS_OFS, 8'h01);
    @(posedge clk);
    mask <= 1'b1;
    irq_req <= 1'b1;
    tick(6);
    chk("cpu_halt", 32'h1, 32'(halt));
    @(posedge clk);
    mask <= 1'b0;
    wait_exc(1'b0, n);
    @(posedge clk);
    irq_req <= 1'b0;
    chk("cpu_halt", 32'h0, 32'(halt));
  endtask : t_sleep
  task automatic t_hw_standby_pin_n_refuse;
    int n;
    enter_hw_standby_pin_n(8'h90);
    chk("lost_hw_standby_pin_n", 32'(HW_STANDBY_PIN_N_LOSS_MASK), 32'(lost & HW_STANDBY_PIN_N_LOSS_MASK));
    @(posedge clk);
    irqn <= 8'hF6;
    tick(8);
    chk("osc_enable", 32'h0, 32'(osc));
    @(posedge clk);
    irq_en <= 8'hFF;
    mask <= 1'b1;
    tick(8);
    chk("osc_enable", 32'h0, 32'(osc));
    @(posedge clk);
    irq_en <= 8'h08;
    mask <= 1'b0;
    tick(8);
    chk("osc_enable", 32'h0, 32'(osc));
    @(posedge clk);
    irq_en <= 8'h01;
    wait_exc(1'b0, n);
    chk("settle", 32'(BASE << 1), 32'(n));
    chk("stop_out", 32'h4000, 32'(mstop));
    @(posedge clk);
    irqn <= 8'hFF;
  endtask : t_hw_standby_pin_n_refuse
  // External clock, no flash: crystal wait and 16-state bans off
  task automatic t_settle;
    logic [2:0] sel [4];
    int n;
    sel = '{3'h0, 3'h1, 3'h2, 3'h7};
    foreach (sel[i])
    begin
      enter_hw_standby_pin_n({1'b1, sel[i], 4'h0});
      @(posedge clk);
      irqn <= 8'h7F;
      irq_en <= 8'h80;
      wait_exc(1'b0, n);
      chk("settle", (sel[i] == 3'h7) ? 32'(SETTLE_SHORT) : 32'(BASE << sel[i]), 32'(n));
      @(posedge clk);
      irqn <= 8'hFF;
    end
  endtask : t_settle
  task automatic t_nmi;
    int n;
    wr_reg(SYS_CTRL_OFS, 8'h08);
    @(posedge clk);
    nmi <= 1'b1;
    enter_hw_standby_pin_n(8'hF0);
    @(posedge clk);
    nmi <= 1'b0;
    tick(8);
    chk("osc_enable", 32'h0, 32'(osc));
    @(posedge clk);
    nmi <= 1'b1;
    wait_exc(1'b0, n);
    wr_reg(SYS_CTRL_OFS, 8'h00);
    enter_hw_standby_pin_n(8'hF0);
    @(posedge clk);
    nmi <= 1'b0;
    wait_exc(1'b0, n);
    chk("settle", 32'(SETTLE_SHORT), 32'(n));
  endtask : t_nmi
  task automatic t_reset_pin;
    int n;
    enter_hw_standby_pin_n(8'h80);
    @(posedge clk);
    rst_req <= 1'b1;
    @(posedge clk);
    rst_req <= 1'b0;
    tick(6);
    chk("osc_enable", 32'h1, 32'(osc));
    chk("clk_enable", 32'h1, 32'(cen));
    chk("reset_state", 32'h1, 32'(rstate));
    wait_exc(1'b1, n);
    rd_chk("stop_high", STOP_HIGH_OFS, 8'h3F);
  endtask : t_reset_pin
  task automatic t_hw_hw_standby_pin_n;
    int n;
    wr_reg(STOP_LOW_OFS, 8'h00);
    pulse_sleep;
    @(posedge clk);
    hpin <= 1'b0;
    tick(6);
    chk("hw_standby", 32'h1, 32'(hws));
    chk("osc_enable", 32'h0, 32'(osc));
    chk("stop_out", 32'h3FFC, 32'(mstop));
    @(posedge clk);
    hpin <= 1'b1;
    wait_exc(1'b1, n);
    chk("hw_standby", 32'h0, 32'(hws));
  endtask : t_hw_hw_standby_pin_n
  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("Checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_stop;
    t_collide;
    t_mode_bits;
    t_sleep;
    t_hw_standby_pin_n_refuse;
    t_settle;
    t_nmi;
    t_reset_pin;
    t_hw_hw_standby_pin_n;
    close_out;
  end
endmodule : pdmc_top_tb

// File: src/pdmc_pkg.sv
// Constants, types and register map of the power-down mode controller
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Sleep: halt CPU only, peripherals keep running
// - Accepted interrupt ends sleep; masked ones do not
// - Reset pin low enters reset; release starts reset
// - Standby pin low enters hardware standby
// - Stop bit set halts module at bus end
// - Stop bit clear resumes module at bus end
// - Serial, ADC, PWM state lost while stopped
// - After reset all but transfer controller stopped
// - Stopped module register accesses are blocked
// - Stop bit to module mapping as listed
// - Stop bits 1 and 0 storage only
// - Transfer controller bus request beats stop write
// - Software standby stops CPU, peripherals, oscillator
// - NMI or enabled IRQ 0,1,2,6,7 wakes after settling count
// - Disabled or masked IRQ keeps standby
// - Reset pin in standby restarts clocks at once
// - Settling select picks the state count
// - NMI edge select: 0 falling, 1 rising
// - Stop pair resets to 3FFF, kept in software standby
//////////////////////////////////////////////////////////////////////////////
package pdmc_pkg;

  // Register byte addresses
  localparam logic [4:0] HW_STANDBY_PIN_N_CTRL_OFS  = 5'h00;
  localparam logic [4:0] LOW_PWR_OFS    = 5'h04;
  localparam logic [4:0] TMR_CTRL_OFS   = 5'h08;
  localparam logic [4:0] SYS_CTRL_OFS   = 5'h0C;
  localparam logic [4:0] STOP_HIGH_OFS  = 5'h10;
  localparam logic [4:0] STOP_LOW_OFS   = 5'h14;
  localparam logic [4:0] STATUS_OFS     = 5'h18;

  // Field positions
  localparam int HW_STANDBY_PIN_N_SEL_POS   = 7;
  localparam int SETTLE_SEL_POS = 4;
  localparam int LOW_SPEED_POS  = 6;
  localparam int PRESCALE_POS   = 4;
  localparam int NMI_EDGE_POS   = 3;
  localparam int XFER_CTRL_BIT  = 14;

  // Reset values
  localparam logic [15:0] STOP_PAIR_RST  = 16'h3FFF;
  // Stop bits that gate a real module (15, 1, 0 do not)
  localparam logic [15:0] STOP_LIVE_MASK = 16'h7FFC;
  // Modules whose state is lost: serial 7-5, ADC 9, PWM 11
  localparam logic [15:0] STOP_LOSS_MASK = 16'h0AE0;
  // Modules lost in software standby: serial and PWM
  localparam logic [15:0] HW_STANDBY_PIN_N_LOSS_MASK = 16'h08E0;
  // IRQ lines able to end software standby: 0,1,2,6,7
  localparam logic [7:0]  WAKE_IRQ_MASK  = 8'hC7;

  // Settling counts in states
  localparam int unsigned SETTLE_BASE_DEF  = 8192;
  localparam int unsigned SETTLE_SHORT     = 16;
  localparam logic [2:0]  SETTLE_SHORT_SEL = 3'h7;
  localparam logic [2:0]  SETTLE_RSVD_SEL  = 3'h6;
  localparam logic [2:0]  SETTLE_MAX_SHIFT = 3'h5;

  typedef enum logic [2:0] {
    PDMC_ACTIVE,
    PDMC_SLEEP,
    PDMC_SW_HW_STANDBY_PIN_N,
    PDMC_SETTLE,
    PDMC_HW_HW_STANDBY_PIN_N,
    PDMC_RESET
  } pdmc_mode_t;

  typedef struct packed {
    logic       standby_select_bit;
    logic [2:0] settling_select;
    logic       low_speed_on_bit;
    logic       prescaler_select_bit;
    logic       nmi_edge_select;
  } pdmc_cfg_t;

  localparam pdmc_cfg_t CFG_RST = '0;

endpackage : pdmc_pkg

// File: src/pdmc_top.sv
// Power-down mode controller: mode sequencer, module stop and register slave
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module pdmc_top
  import pdmc_pkg::*;
#(
  parameter int unsigned SETTLE_BASE = SETTLE_BASE_DEF
)(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // CPU and interrupt logic
  input  wire logic        sleep_instr_in,
  input  wire logic        irq_accept_in,
  input  wire logic        cpu_mask_in,
  input  wire logic [7:0]  irq_enable_in,
  output logic             cpu_halt_out,
  output logic             irq_exc_start_out,
  output logic             reset_exc_start_out,
  output logic             reset_state_out,
  // Pins
  input  wire logic        reset_pin_n_in,
  input  wire logic        hw_standby_pin_n_in,
  input  wire logic        nmi_pin_in,
  input  wire logic [7:0]  irq_pin_n_in,
  // Clock oscillator
  output logic             osc_enable_out,
  output logic             chip_clk_enable_out,
  output logic             hw_standby_out,
  // Peripherals
  input  wire logic        xfer_bus_req_in,
  input  wire logic        bus_cycle_end_in,
  output logic [15:0]      module_stop_out,
  output logic [15:0]      module_state_lost_out,
  output logic [15:0]      reg_access_block_out
);

  //////////////////////////////////////////////////////////////////////////
  // Settling count for a select value
  function automatic logic [18:0] settle_count(input logic [2:0] sel);
    logic [18:0] base;
    base = SETTLE_BASE[18:0];
    if (sel == SETTLE_SHORT_SEL)
      settle_count = SETTLE_SHORT[18:0];
    else if (sel == SETTLE_RSVD_SEL)
      settle_count = base << SETTLE_MAX_SHIFT;
    else
      settle_count = base << sel;
  endfunction : settle_count

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [11:0] pin_meta_q;
  logic [11:0] pin_sync_q;
  logic        nmi_prev_q;

  always_ff @(posedge ref_clk_in)
  begin
    pin_meta_q <= {reset_pin_n_in, hw_standby_pin_n_in, nmi_pin_in,
                   irq_pin_n_in, 1'b0};
    pin_sync_q <= pin_meta_q;
    nmi_prev_q <= pin_sync_q[9];
  end

  logic       rst_pin_n;
  logic       hw_pin_n;
  logic       nmi_lvl;
  logic [7:0] irq_lvl;
  assign rst_pin_n = pin_sync_q[11];
  assign hw_pin_n  = pin_sync_q[10];
  assign nmi_lvl   = pin_sync_q[9];
  assign irq_lvl   = ~pin_sync_q[8:1];

  //////////////////////////////////////////////////////////////////////////
  // Registers
  pdmc_cfg_t   cfg_q, cfg_d;
  logic [15:0] stop_q, stop_d;
  logic [15:0] applied_q, applied_d;
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  pdmc_mode_t  mode_q, mode_d;
  logic [18:0] cnt_q, cnt_d;
  logic        irq_exc_q, irq_exc_d;
  logic        rst_exc_q, rst_exc_d;

  logic wr_en;
  logic nmi_edge;
  logic irq_wake;
  logic pin_reset;
  logic sleep_go;

  assign wr_en     = ack_q & avs_write_in;
  assign pin_reset = ~rst_pin_n | ~hw_pin_n;

  // Active NMI edge per select bit
  assign nmi_edge = cfg_q.nmi_edge_select ? (nmi_lvl & ~nmi_prev_q)
                                          : (~nmi_lvl & nmi_prev_q);
  // Only enabled, unmasked wake lines count
  assign irq_wake = |(irq_lvl & irq_enable_in & WAKE_IRQ_MASK)
                    & ~cpu_mask_in;
  assign sleep_go = sleep_instr_in & ~cfg_q.low_speed_on_bit;

  //////////////////////////////////////////////////////////////////////////
  // Register file and bus slave
  always_comb
  begin
    cfg_d   = cfg_q;
    stop_d  = stop_q;
    ack_d   = (avs_read_in | avs_write_in) & ~ack_q;
    rdata_d = rdata_q;
    if (ack_d && avs_read_in)
    begin
      rdata_d = '0;
      case (avs_address_in)
        HW_STANDBY_PIN_N_CTRL_OFS:
        begin
          rdata_d[HW_STANDBY_PIN_N_SEL_POS] = cfg_q.standby_select_bit;
          rdata_d[SETTLE_SEL_POS +: 3] = cfg_q.settling_select;
        end
        LOW_PWR_OFS:   rdata_d[LOW_SPEED_POS] = cfg_q.low_speed_on_bit;
        TMR_CTRL_OFS:  rdata_d[PRESCALE_POS]  = cfg_q.prescaler_select_bit;
        SYS_CTRL_OFS:  rdata_d[NMI_EDGE_POS]  = cfg_q.nmi_edge_select;
        STOP_HIGH_OFS: rdata_d[7:0] = stop_q[15:8];
        STOP_LOW_OFS:  rdata_d[7:0] = stop_q[7:0];
        STATUS_OFS:    rdata_d[2:0] = mode_q;
        default:       rdata_d = '0;
      endcase
    end
    if (wr_en)
    begin
      case (avs_address_in)
        HW_STANDBY_PIN_N_CTRL_OFS:
        begin
          cfg_d.standby_select_bit = avs_writedata_in[HW_STANDBY_PIN_N_SEL_POS];
          cfg_d.settling_select = avs_writedata_in[SETTLE_SEL_POS +: 3];
        end
        LOW_PWR_OFS:
          cfg_d.low_speed_on_bit = avs_writedata_in[LOW_SPEED_POS];
        TMR_CTRL_OFS:
          cfg_d.prescaler_select_bit = avs_writedata_in[PRESCALE_POS];
        SYS_CTRL_OFS:
          cfg_d.nmi_edge_select = avs_writedata_in[NMI_EDGE_POS];
        STOP_HIGH_OFS:
        begin
          stop_d[15:8] = avs_writedata_in[7:0];
          // Bus request wins; stop bit not set
          if (xfer_bus_req_in && !stop_q[XFER_CTRL_BIT])
            stop_d[XFER_CTRL_BIT] = 1'b0;
        end
        STOP_LOW_OFS:
          stop_d[7:0] = avs_writedata_in[7:0];
        default:
          stop_d = stop_q;
      endcase
    end
    // Reset pin or hardware standby reinitialise the pair
    if (pin_reset)
    begin
      stop_d = STOP_PAIR_RST;
      cfg_d  = CFG_RST;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      cfg_q   <= CFG_RST;
      stop_q  <= STOP_PAIR_RST;
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      cfg_q   <= cfg_d;
      stop_q  <= stop_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Module stop application at bus cycle end
  always_comb
  begin
    applied_d = applied_q;
    if (bus_cycle_end_in || pin_reset)
      applied_d = stop_q & STOP_LIVE_MASK;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
      applied_q <= STOP_PAIR_RST & STOP_LIVE_MASK;
    else
      applied_q <= applied_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode sequencer
  always_comb
  begin
    mode_d    = mode_q;
    cnt_d     = cnt_q;
    irq_exc_d = 1'b0;
    rst_exc_d = 1'b0;
    case (mode_q)
      PDMC_ACTIVE:
      begin
        if (sleep_go && !cfg_q.standby_select_bit)
          mode_d = PDMC_SLEEP;
        else if (sleep_go && !cfg_q.prescaler_select_bit)
          mode_d = PDMC_SW_HW_STANDBY_PIN_N;
      end
      PDMC_SLEEP:
      begin
        if (irq_accept_in)
        begin
          mode_d    = PDMC_ACTIVE;
          irq_exc_d = 1'b1;
        end
      end
      PDMC_SW_HW_STANDBY_PIN_N:
      begin
        if (nmi_edge || irq_wake)
        begin
          mode_d = PDMC_SETTLE;
          cnt_d  = settle_count(cfg_q.settling_select);
        end
      end
      PDMC_SETTLE:
      begin
        cnt_d = cnt_q - 19'h00001;
        if (cnt_q == 19'h00001)
        begin
          mode_d    = PDMC_ACTIVE;
          irq_exc_d = 1'b1;
        end
      end
      PDMC_HW_HW_STANDBY_PIN_N:
      begin
        if (hw_pin_n)
          mode_d = PDMC_RESET;
      end
      PDMC_RESET:
      begin
        if (rst_pin_n)
        begin
          mode_d    = PDMC_ACTIVE;
          rst_exc_d = 1'b1;
        end
      end
      default:
        mode_d = PDMC_RESET;
    endcase
    // Standby pin overrides every mode; reset pin every mode but hardware standby
    if (!hw_pin_n)
    begin
      mode_d    = PDMC_HW_HW_STANDBY_PIN_N;
      irq_exc_d = 1'b0;
      rst_exc_d = 1'b0;
    end
    else if (!rst_pin_n && mode_q != PDMC_HW_HW_STANDBY_PIN_N)
    begin
      mode_d    = PDMC_RESET;
      irq_exc_d = 1'b0;
      rst_exc_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      mode_q    <= PDMC_RESET;
      cnt_q     <= '0;
      irq_exc_q <= 1'b0;
      rst_exc_q <= 1'b0;
    end
    else
    begin
      mode_q    <= mode_d;
      cnt_q     <= cnt_d;
      irq_exc_q <= irq_exc_d;
      rst_exc_q <= rst_exc_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic        halt_q;
  logic        osc_q;
  logic        clk_en_q;
  logic        hws_q;
  logic        rst_st_q;
  logic [15:0] lost_q;
  logic        in_sw;

  assign in_sw = (mode_d == PDMC_SW_HW_STANDBY_PIN_N) || (mode_d == PDMC_SETTLE);

  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      halt_q   <= 1'b1;
      osc_q    <= 1'b1;
      clk_en_q <= 1'b1;
      hws_q    <= 1'b0;
      rst_st_q <= 1'b1;
      lost_q   <= STOP_LOSS_MASK;
    end
    else
    begin
      halt_q   <= mode_d != PDMC_ACTIVE;
      osc_q    <= (mode_d != PDMC_SW_HW_STANDBY_PIN_N) && (mode_d != PDMC_HW_HW_STANDBY_PIN_N);
      clk_en_q <= !in_sw && (mode_d != PDMC_HW_HW_STANDBY_PIN_N);
      hws_q    <= mode_d == PDMC_HW_HW_STANDBY_PIN_N;
      rst_st_q <= (mode_d == PDMC_RESET) || (mode_d == PDMC_HW_HW_STANDBY_PIN_N);
      lost_q   <= (applied_d & STOP_LOSS_MASK)
                  | (in_sw ? HW_STANDBY_PIN_N_LOSS_MASK : 16'h0000);
    end
  end

  assign avs_readdata_out      = rdata_q;
  assign avs_waitrequest_out   = ~ack_q;
  assign cpu_halt_out          = halt_q;
  assign irq_exc_start_out     = irq_exc_q;
  assign reset_exc_start_out   = rst_exc_q;
  assign reset_state_out       = rst_st_q;
  assign osc_enable_out        = osc_q;
  assign chip_clk_enable_out   = clk_en_q;
  assign hw_standby_out        = hws_q;
  assign module_stop_out       = applied_q;
  assign module_state_lost_out = lost_q;
  assign reg_access_block_out  = applied_q;

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_sleep_keeps_clocks;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    mode_q == PDMC_SLEEP |-> (chip_clk_enable_out && cpu_halt_out);
  endproperty
  a_sleep_keeps_clocks: assert property (p_sleep_keeps_clocks)
    else $error("sleep mode lost clocks or CPU ran");

  property p_sleep_wake;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (mode_q == PDMC_SLEEP && irq_accept_in && hw_pin_n && rst_pin_n)
      |=> (mode_q == PDMC_ACTIVE && irq_exc_start_out);
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("sleep not ended by accepted interrupt");

  property p_reset_pin;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (!rst_pin_n && hw_pin_n && mode_q != PDMC_HW_HW_STANDBY_PIN_N)
      |=> (reset_state_out && chip_clk_enable_out && osc_enable_out);
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("reset pin did not give clocked reset state");

  property p_hw_standby;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    !hw_pin_n |=> (hw_standby_out && !osc_enable_out);
  endproperty
  a_hw_standby: assert property (p_hw_standby)
    else $error("standby pin did not enter hardware standby");

  property p_stop_at_bus_end;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (bus_cycle_end_in && !pin_reset)
      |=> module_stop_out == ($past(stop_q) & STOP_LIVE_MASK);
  endproperty
  a_stop_at_bus_end: assert property (p_stop_at_bus_end)
    else $error("module stop not applied at bus end");

  property p_stop_holds;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (!bus_cycle_end_in && !pin_reset) |=> $stable(module_stop_out);
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("module stop changed outside bus end");

  property p_dead_bits;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (module_stop_out & ~STOP_LIVE_MASK) == 16'h0000;
  endproperty
  a_dead_bits: assert property (p_dead_bits)
    else $error("unassigned stop bit reached a module");

  property p_xfer_collision;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (wr_en && avs_address_in == STOP_HIGH_OFS && xfer_bus_req_in
      && !stop_q[XFER_CTRL_BIT] && !pin_reset) |=> !stop_q[XFER_CTRL_BIT];
  endproperty
  a_xfer_collision: assert property (p_xfer_collision)
    else $error("stop bit set despite transfer request");

  property p_settle_gated;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (mode_q == PDMC_SW_HW_STANDBY_PIN_N && mode_d == PDMC_SETTLE)
      |=> !chip_clk_enable_out [*8];
  endproperty
  a_settle_gated: assert property (p_settle_gated)
    else $error("clocks released during settling");

  property p_settle_end;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (mode_q == PDMC_SETTLE && cnt_q == 19'h00001 && !pin_reset)
      |=> (irq_exc_start_out && chip_clk_enable_out);
  endproperty
  a_settle_end: assert property (p_settle_end)
    else $error("settling end did not wake the chip");

  property p_masked_irq;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (mode_q == PDMC_SW_HW_STANDBY_PIN_N && cpu_mask_in && !nmi_edge && !pin_reset)
      |=> mode_q == PDMC_SW_HW_STANDBY_PIN_N;
  endproperty
  a_masked_irq: assert property (p_masked_irq)
    else $error("masked request ended standby");

  property p_stop_reset;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    pin_reset |=> stop_q == STOP_PAIR_RST;
  endproperty
  a_stop_reset: assert property (p_stop_reset)
    else $error("stop pair not reinitialised");

  c_sleep_wake: cover property (@(posedge ref_clk_in) disable iff (!resetn_in)
    mode_q == PDMC_SLEEP ##1 mode_q == PDMC_ACTIVE);
  c_standby_wake: cover property (@(posedge ref_clk_in) disable iff (!resetn_in)
    mode_q == PDMC_SETTLE ##1 mode_q == PDMC_ACTIVE);
  c_hw_standby: cover property (@(posedge ref_clk_in) disable iff (!resetn_in)
    mode_q == PDMC_HW_HW_STANDBY_PIN_N ##1 mode_q == PDMC_RESET);

endmodule : pdmc_top
